// File: rtl/flash_lock_pkg.sv
// Purpose: Shared constants, types and decode function for the lock and power-down controller.
// Assumes: 24-bit flash addresses, 2 MB array made of 32 blocks of 64 kB.
// Notes: Register offsets are AXI4-Lite byte addresses.
`default_nettype none
package flash_lock_pkg;
   localparam logic [7:0] OP_LOCK = 8'h36;
   localparam logic [7:0] OP_UNLOCK = 8'h39;
   localparam logic [7:0] OP_GLOCK = 8'h7e;
   localparam logic [7:0] OP_GUNLOCK = 8'h98;
   localparam logic [7:0] OP_RDLOCK_A = 8'h3c;
   localparam logic [7:0] OP_RDLOCK_B = 8'h3d;
   localparam logic [7:0] OP_PD = 8'hb9;
   localparam logic [7:0] OP_PD_LEGACY = 8'h79;
   localparam logic [7:0] OP_RESUME = 8'hab;
   localparam logic [7:0] OP_RST_EN = 8'h66;
   localparam logic [7:0] OP_RST = 8'h99;
   localparam logic [7:0] OP_TERM = 8'hf0;
   localparam int NUM_LOCKS = 62;
   localparam logic [5:0] LOCK_MID_BASE = 6'h0f;
   localparam logic [5:0] LOCK_TOP_BASE = 6'h2e;
   localparam logic [4:0] BLK_BOTTOM = 5'h00;
   localparam logic [4:0] BLK_TOP = 5'h1f;
   localparam logic [5:0] CNT_OPCODE = 6'h08;
   localparam logic [5:0] CNT_ADDR = 6'h20;
   localparam logic [5:0] CNT_MAX = 6'h3f;
   localparam int SR3_WPS_BIT = 2;
   localparam int SR3_PIN_BIT = 7;
   localparam int SR4_PDM_BIT = 7;
   localparam logic [7:0] SR3_RESET = 8'h00;
   localparam logic [7:0] SR4_RESET = 8'h00;
   localparam logic [7:0] FIELD_LOCKED = 8'h01;
   localparam logic [7:0] FIELD_OPEN = 8'h00;
   localparam logic [31:0] REG_SR3 = 32'h0000_0000;
   localparam logic [31:0] REG_SR4 = 32'h0000_0004;
   localparam logic [31:0] REG_STATE = 32'h0000_0008;
   localparam logic [31:0] REG_LOCK_LO = 32'h0000_000c;
   localparam logic [31:0] REG_LOCK_HI = 32'h0000_0010;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [2:0] {PWR_ACTIVE = 3'b001, PWR_DEEP = 3'b010,
      PWR_ULTRA = 3'b100} pwr_t;
   typedef enum logic [3:0] {SPI_CMD = 4'b0001, SPI_ADDR = 4'b0010,
      SPI_DATA = 4'b0100, SPI_SKIP = 4'b1000} spi_t;
   typedef struct packed {
      logic sclk; logic cs_n; logic si; logic hw_rst_n; logic jedec;
   } pins_t;
   localparam pins_t PINS_IDLE = 5'b01010;
   typedef struct packed {
      pins_t s1; pins_t s2; pins_t prev;
      spi_t spi; logic [5:0] bit_cnt; logic [7:0] opcode;
      logic [23:0] addr; logic [7:0] out_sh; logic so_data; logic so_oe;
      pwr_t pwr; logic rst_armed; logic [NUM_LOCKS-1:0] locks;
      logic [7:0] sr3; logic [7:0] sr4;
      logic pe_blocked; logic pe_halt; logic dev_reset; logic sram_lost;
      logic awready; logic wready; logic bvalid; logic [1:0] bresp;
      logic arready; logic rvalid; logic [1:0] rresp; logic [31:0] rdata;
   } state_t;
   localparam state_t ST_RESET = '{s1: PINS_IDLE, s2: PINS_IDLE,
      prev: PINS_IDLE, spi: SPI_CMD, pwr: PWR_ACTIVE, sr3: SR3_RESET,
      sr4: SR4_RESET, default: '0};
   // Bottom sub-blocks take 0..15, blocks 1..30 take 16..45, top ones 46..61.
   function automatic logic [5:0] lock_index(input logic [23:0] a);
      if (a[20:16] == BLK_BOTTOM)
         return {2'b00, a[15:12]};
      else if (a[20:16] == BLK_TOP)
         return LOCK_TOP_BASE + {2'b00, a[15:12]};
      else
         return LOCK_MID_BASE + {1'b0, a[20:16]};
   endfunction
endpackage
`default_nettype wire

// File: rtl/flash_lock_ctrl.sv
// Purpose: Lock bits, lock readout, power-down modes and reset handling of a serial flash.
// Assumes: SPI pins and reset requests are asynchronous to mclk; SPI mode 0 or 3.
// Notes: Commands act on the rising edge of chip select; lock readout shifts on falling sclk.
`default_nettype none
module flash_lock_ctrl
   import flash_lock_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   output logic so_data,
   output logic so_oe,
   input wire logic hw_reset_n,
   input wire logic jedec_reset,
   input wire logic pe_busy,
   input wire logic [23:0] pe_addr,
   output logic pe_blocked,
   output logic pe_halt,
   output logic dev_reset,
   output logic sram_lost,
   output logic deep_sleep_mode,
   output logic ultra_sleep_mode,
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   state_t st;
   state_t next_st;
   pins_t pin_now;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;
   logic cs_act;
   logic reset_evt;
   logic short_done;
   logic addr_done;
   logic [7:0] op8;
   logic [23:0] addr24;

   assign pin_now = '{sclk: sclk, cs_n: cs_n, si: si,
      hw_rst_n: hw_reset_n, jedec: jedec_reset};
   assign sclk_rise = st.s2.sclk & ~st.prev.sclk;
   assign sclk_fall = ~st.s2.sclk & st.prev.sclk;
   assign cs_rise = st.s2.cs_n & ~st.prev.cs_n;
   assign cs_act = ~st.s2.cs_n;
   // The pin only counts once software has enabled its reset function.
   assign reset_evt = (~st.s2.hw_rst_n & st.prev.hw_rst_n & st.sr3[SR3_PIN_BIT])
      | (st.s2.jedec & ~st.prev.jedec);
   assign short_done = cs_rise && st.spi == SPI_CMD && st.bit_cnt == CNT_OPCODE;
   assign addr_done = cs_rise && st.spi == SPI_ADDR && st.bit_cnt == CNT_ADDR;
   assign op8 = {st.opcode[6:0], st.s2.si};
   assign addr24 = {st.addr[22:0], st.s2.si};

   always_comb
   begin
      next_st = st;
      next_st.s1 = pin_now;
      next_st.s2 = st.s1;
      next_st.prev = st.s2;
      next_st.pe_halt = 1'b0;
      next_st.dev_reset = 1'b0;
      next_st.sram_lost = 1'b0;
      next_st.pe_blocked = st.sr3[SR3_WPS_BIT] & st.locks[lock_index(pe_addr)];
      next_st.awready = 1'b0;
      next_st.wready = 1'b0;
      next_st.arready = 1'b0;
      if (st.bvalid && bready)
         next_st.bvalid = 1'b0;
      if (st.rvalid && rready)
         next_st.rvalid = 1'b0;
      if (awvalid && wvalid && !st.awready && !st.bvalid)
      begin
         next_st.awready = 1'b1;
         next_st.wready = 1'b1;
      end
      if (st.awready)
      begin
         next_st.bvalid = 1'b1;
         next_st.bresp = RESP_OKAY;
         if (awaddr == REG_SR3)
         begin
            if (wstrb[0])
               next_st.sr3 = wdata[7:0];
         end
         else if (awaddr == REG_SR4)
         begin
            if (wstrb[0])
               next_st.sr4 = wdata[7:0];
         end
         else if (awaddr != REG_STATE && awaddr != REG_LOCK_LO
            && awaddr != REG_LOCK_HI)
            next_st.bresp = RESP_SLVERR;
      end
      if (arvalid && !st.arready && !st.rvalid)
         next_st.arready = 1'b1;
      if (st.arready)
      begin
         next_st.rvalid = 1'b1;
         next_st.rresp = RESP_OKAY;
         next_st.rdata = 32'h0000_0000;
         if (araddr == REG_SR3)
            next_st.rdata = {24'h00_0000, st.sr3};
         else if (araddr == REG_SR4)
            next_st.rdata = {24'h00_0000, st.sr4};
         else if (araddr == REG_STATE)
            next_st.rdata = {26'h000_0000, pe_busy, st.rst_armed, st.so_oe, st.pwr};
         else if (araddr == REG_LOCK_LO)
            next_st.rdata = st.locks[31:0];
         else if (araddr == REG_LOCK_HI)
            next_st.rdata = {2'b00, st.locks[NUM_LOCKS-1:32]};
         else
            next_st.rresp = RESP_SLVERR;
      end

      if (cs_rise)
      begin
         // Frame end returns to opcode phase and drops the readout output enable.
         next_st.spi = SPI_CMD;
         next_st.bit_cnt = 6'h00;
         next_st.so_oe = 1'b0;
         if (short_done)
         begin
            next_st.rst_armed = 1'b0;
            case (st.pwr)
               PWR_ACTIVE:
               begin
                  case (st.opcode)
                     OP_GLOCK: next_st.locks = '1;
                     OP_GUNLOCK: next_st.locks = '0;
                     OP_PD:
                     begin
                        if (st.sr4[SR4_PDM_BIT])
                           next_st.pwr = PWR_DEEP;
                        else
                        begin
                           next_st.pwr = PWR_ULTRA;
                           next_st.sram_lost = 1'b1;
                        end
                     end
                     OP_PD_LEGACY:
                     begin
                        next_st.pwr = PWR_ULTRA;
                        next_st.sram_lost = 1'b1;
                     end
                     OP_RST_EN: next_st.rst_armed = 1'b1;
                     OP_RST: next_st.dev_reset = st.rst_armed;
                     OP_TERM: next_st.pe_halt = pe_busy;
                     default: ;
                  endcase
               end
               PWR_DEEP:
               begin
                  // Other opcodes, F0h among them, leave deep sleep alone.
                  if (st.opcode == OP_RESUME)
                     next_st.pwr = PWR_ACTIVE;
                  else if (st.opcode == OP_RST_EN)
                     next_st.rst_armed = 1'b1;
                  else if (st.opcode == OP_RST && st.rst_armed)
                  begin
                     next_st.pwr = PWR_ACTIVE;
                     next_st.dev_reset = 1'b1;
                  end
               end
               PWR_ULTRA:
               begin
                  // Only resume leaves; the reset pair and F0h are ignored.
                  if (st.opcode == OP_RESUME)
                  begin
                     next_st.pwr = PWR_ACTIVE;
                     next_st.dev_reset = 1'b1;
                     next_st.sram_lost = 1'b1;
                  end
               end
               default: next_st.pwr = PWR_ACTIVE;
            endcase
         end
         else if (addr_done && st.opcode == OP_LOCK)
            next_st.locks[lock_index(st.addr)] = 1'b1;
         else if (addr_done && st.opcode == OP_UNLOCK)
            next_st.locks[lock_index(st.addr)] = 1'b0;
         else
            next_st.rst_armed = 1'b0;
      end
      else if (cs_act && sclk_rise)
      begin
         if (st.bit_cnt != CNT_MAX)
            next_st.bit_cnt = st.bit_cnt + 6'h01;
         case (st.spi)
            SPI_CMD:
            begin
               if (st.bit_cnt < CNT_OPCODE)
                  next_st.opcode = op8;
               if (st.bit_cnt == CNT_OPCODE - 6'h01
                  && (op8 == OP_LOCK || op8 == OP_UNLOCK
                  || op8 == OP_RDLOCK_A || op8 == OP_RDLOCK_B))
               begin
                  if (st.pwr == PWR_ACTIVE)
                     next_st.spi = SPI_ADDR;
                  else
                     next_st.spi = SPI_SKIP;
               end
            end
            SPI_ADDR:
            begin
               next_st.addr = addr24;
               if (st.bit_cnt == CNT_ADDR - 6'h01
                  && (st.opcode == OP_RDLOCK_A || st.opcode == OP_RDLOCK_B))
               begin
                  next_st.spi = SPI_DATA;
                  next_st.so_oe = 1'b1;
                  next_st.out_sh = st.locks[lock_index(addr24)]
                     ? FIELD_LOCKED : FIELD_OPEN;
               end
            end
            default: ;
         endcase
      end
      else if (cs_act && sclk_fall && st.spi == SPI_DATA)
      begin
         // The field repeats for as long as the host keeps clocking.
         next_st.so_data = st.out_sh[7];
         next_st.out_sh = {st.out_sh[6:0], st.out_sh[7]};
      end

      if (reset_evt)
      begin
         // Pin and JEDEC resets win over any command but a lock change and end either sleep.
         next_st.pwr = PWR_ACTIVE;
         next_st.dev_reset = 1'b1;
         next_st.sram_lost = 1'b1;
         next_st.spi = SPI_CMD;
         next_st.bit_cnt = 6'h00;
         next_st.so_oe = 1'b0;
         next_st.rst_armed = 1'b0;
         next_st.pe_halt = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         st <= ST_RESET;
      else
         st <= next_st;
   end

   assign so_data = st.so_data;
   assign so_oe = st.so_oe;
   assign pe_blocked = st.pe_blocked;
   assign pe_halt = st.pe_halt;
   assign dev_reset = st.dev_reset;
   assign sram_lost = st.sram_lost;
   assign deep_sleep_mode = st.pwr[1];
   assign ultra_sleep_mode = st.pwr[2];
   assign awready = st.awready;
   assign wready = st.wready;
   assign bresp = st.bresp;
   assign bvalid = st.bvalid;
   assign arready = st.arready;
   assign rdata = st.rdata;
   assign rresp = st.rresp;
   assign rvalid = st.rvalid;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_global_lock: assert property (
      short_done && st.opcode == OP_GLOCK && st.pwr == PWR_ACTIVE && !reset_evt
      |=> &st.locks)
      else $error("global lock did not set every bit");

   a_global_unlock: assert property (
      short_done && st.opcode == OP_GUNLOCK && st.pwr == PWR_ACTIVE
      |=> st.locks == '0)
      else $error("global unlock did not clear every bit");

   a_single_lock: assert property (
      addr_done && st.opcode == OP_LOCK && !reset_evt
      |=> st.locks[lock_index($past(st.addr))])
      else $error("individual lock bit not set");

   a_single_unlock: assert property (
      addr_done && st.opcode == OP_UNLOCK
      |=> !st.locks[lock_index($past(st.addr))])
      else $error("individual lock bit not cleared");

   a_field_load: assert property (
      st.spi == SPI_ADDR && st.bit_cnt == CNT_ADDR - 6'h01 && cs_act
      && sclk_rise && !cs_rise && !reset_evt && st.opcode == OP_RDLOCK_B
      |=> st.so_oe && st.out_sh == {7'h00, st.locks[lock_index(st.addr)]})
      else $error("lock field not loaded for readout");

   a_pe_gate: assert property (
      ##1 pe_blocked == $past(st.sr3[SR3_WPS_BIT] && st.locks[lock_index(pe_addr)]))
      else $error("program/erase gate wrong");

   a_deep_entry: assert property (
      short_done && st.opcode == OP_PD && st.pwr == PWR_ACTIVE
      && st.sr4[SR4_PDM_BIT] && !reset_evt
      |=> (deep_sleep_mode && !sram_lost) [*2])
      else $error("deep sleep entry wrong");

   a_ultra_entry: assert property (
      short_done && st.opcode == OP_PD_LEGACY && st.pwr == PWR_ACTIVE && !reset_evt
      |=> ##1 ultra_sleep_mode && !deep_sleep_mode)
      else $error("legacy opcode did not enter ultra sleep");

   a_deep_resume: assert property (
      short_done && st.opcode == OP_RESUME && st.pwr == PWR_DEEP && !reset_evt
      |=> st.pwr == PWR_ACTIVE && !st.dev_reset && !st.sram_lost)
      else $error("deep resume wrong");

   a_ultra_resume: assert property (
      short_done && st.opcode == OP_RESUME && st.pwr == PWR_ULTRA
      |=> st.dev_reset && st.pwr == PWR_ACTIVE)
      else $error("ultra resume did not reset");

   a_ultra_holds: assert property (
      st.pwr == PWR_ULTRA && !reset_evt
      && !(short_done && st.opcode == OP_RESUME)
      |=> st.pwr == PWR_ULTRA)
      else $error("ultra sleep left without resume or reset");

   a_ext_reset: assert property (
      reset_evt |=> st.pwr == PWR_ACTIVE && dev_reset && sram_lost ##1 !dev_reset)
      else $error("external reset not applied");

   a_terminate: assert property (
      short_done && st.opcode == OP_TERM && st.pwr == PWR_ACTIVE
      && pe_busy && !reset_evt
      |=> pe_halt && !dev_reset)
      else $error("terminate did not halt");

   c_deep_cycle: cover property (
      deep_sleep_mode ##[1:1000] !deep_sleep_mode);
   c_ultra_cycle: cover property (
      ultra_sleep_mode ##[1:1000] dev_reset);
   c_readout: cover property (st.spi == SPI_DATA && so_oe);
   c_reset_pair: cover property (short_done && st.opcode == OP_RST && st.rst_armed);
endmodule
`default_nettype wire

// File: testbench/spi_host_model.sv
// Purpose: SPI host model that frames flash commands and reads back the lock field.
// Assumes: SPI mode 0 with a 160 ns serial clock built from mclk counts.
// Notes: The serial clock rests low between frames and unused data-in bits are inverted.
`default_nettype none
module spi_host_model
(
   input wire logic mclk,
   output var logic sclk,
   output var logic cs_n,
   output var logic si,
   input wire logic so_data,
   input wire logic so_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   // Opcode then address leave MSB first; extra clocks shift the field in.
   task automatic frame(input logic [31:0] word, input int nbits, input int nrd,
      output logic [7:0] field);
      int i;
      field = 8'h00;
      @(posedge mclk);
      cs_n <= 1'b0;
      for (i = 0; i < nbits + nrd; i++)
      begin
         si <= (i < nbits) ? word[31 - i] : ~si;
         repeat (20) @(posedge mclk);
         sclk <= 1'b1;
         if (i >= nbits)
            field = {field[6:0], (so_oe === 1'b1) ? so_data : 1'bx};
         repeat (20) @(posedge mclk);
         sclk <= 1'b0;
      end
      repeat (20) @(posedge mclk);
      cs_n <= 1'b1;
      si <= ~si;
   endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Purpose: Self-checking bench for the lock and power-down controller.
// Assumes: Register access over AXI4-Lite, commands through the SPI host model.
// Notes: One-cycle pulses are counted by monitors and compared as counts.
`default_nettype none
module testbench
   import flash_lock_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk, rst_n, sclk, cs_n, si, so_data, so_oe, hw_reset_n, jedec_reset, pe_busy;
   logic [23:0] pe_addr;
   logic pe_blocked, pe_halt, dev_reset, sram_lost, deep, ultra;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [3:0] wstrb;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp, r;
   logic [7:0] f;
   int fail_count = 0, checked = 0, cycles = 0, n_rst = 0, n_lost = 0, n_halt = 0, r0, l0;
   spi_host_model host_u (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .si(si),
      .so_data(so_data), .so_oe(so_oe));
   flash_lock_ctrl dut_u (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
      .si(si), .so_data(so_data), .so_oe(so_oe), .hw_reset_n(hw_reset_n),
      .jedec_reset(jedec_reset), .pe_busy(pe_busy), .pe_addr(pe_addr),
      .pe_blocked(pe_blocked), .pe_halt(pe_halt), .dev_reset(dev_reset),
      .sram_lost(sram_lost), .deep_sleep_mode(deep), .ultra_sleep_mode(ultra),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cycles++;
      n_rst += (dev_reset === 1'b1);
      n_lost += (sram_lost === 1'b1);
      n_halt += (pe_halt === 1'b1);
      if (cycles == 80000)
      begin
         fail_count++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge mclk);
         if (awready === 1'b1) aw_done = 1'b1;
         if (wready === 1'b1) w_done = 1'b1;
         if (aw_done) awvalid <= 1'b0;
         if (w_done) wvalid <= 1'b0;
      end
      do @(posedge mclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic reg_chk(input string n, input logic [31:0] a, input logic [31:0] exp,
      input logic [1:0] er);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge mclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge mclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(n, rdata, exp);
      chk("rresp", {30'h0, rresp}, {30'h0, er});
   endtask
   task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int n);
      host_u.frame({op, a}, n, 0, f);
      repeat (8) @(posedge mclk);
   endtask
   task automatic mode_chk(input logic [1:0] exp);
      chk("sleep", {30'h0, deep, ultra}, {30'h0, exp});
   endtask
   task automatic pe_chk(input logic [23:0] a, input logic exp);
      @(posedge mclk);
      pe_addr <= a;
      repeat (3) @(posedge mclk);
      chk("pe_blocked", {31'h0, pe_blocked}, {31'h0, exp});
   endtask
   task automatic t_reset();
      reg_chk("sr3", REG_SR3, {24'h0, SR3_RESET}, RESP_OKAY);
      reg_chk("sr4", REG_SR4, {24'h0, SR4_RESET}, RESP_OKAY);
      reg_chk("state", REG_STATE, 32'h01, RESP_OKAY);
      reg_chk("lock_hi", REG_LOCK_HI, 32'h0, RESP_OKAY);
      reg_chk("unmapped", 32'h40, 32'h0, RESP_SLVERR);
      axi_wr(32'h40, 32'hff);
      chk("bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
   endtask
   task automatic t_lock();
      axi_wr(REG_SR3, 32'h04);
      chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
      cmd(OP_LOCK, 24'h001000, 32);
      cmd(OP_LOCK, 24'h050000, 32);
      cmd(OP_LOCK, 24'h1ff000, 32);
      reg_chk("lock_lo", REG_LOCK_LO, 32'h0010_0002, RESP_OKAY);
      reg_chk("lock_hi", REG_LOCK_HI, 32'h2000_0000, RESP_OKAY);
      host_u.frame({OP_RDLOCK_A, 24'h001000}, 32, 8, f);
      chk("field_a", {24'h0, f}, {24'h0, FIELD_LOCKED});
      host_u.frame({OP_RDLOCK_B, 24'h001000}, 32, 8, f);
      chk("field_b", {24'h0, f}, {24'h0, FIELD_LOCKED});
      host_u.frame({OP_RDLOCK_B, 24'h002000}, 32, 8, f);
      chk("field_open", {24'h0, f}, {24'h0, FIELD_OPEN});
      pe_chk(24'h001000, 1'b1);
      pe_chk(24'h002000, 1'b0);
      axi_wr(REG_SR3, 32'h00);
      pe_chk(24'h001000, 1'b0);
      axi_wr(REG_SR3, 32'h04);
      cmd(OP_UNLOCK, 24'h050000, 32);
      reg_chk("lock_lo", REG_LOCK_LO, 32'h0000_0002, RESP_OKAY);
      cmd(OP_GLOCK, 24'h0, 8);
      reg_chk("lock_lo", REG_LOCK_LO, 32'hffff_ffff, RESP_OKAY);
      reg_chk("lock_hi", REG_LOCK_HI, 32'h3fff_ffff, RESP_OKAY);
      cmd(OP_GUNLOCK, 24'h0, 8);
      reg_chk("lock_lo", REG_LOCK_LO, 32'h0, RESP_OKAY);
      reg_chk("lock_hi", REG_LOCK_HI, 32'h0, RESP_OKAY);
   endtask
   task automatic t_power();
      axi_wr(REG_SR4, 32'h80);
      cmd(OP_PD, 24'h0, 8);
      mode_chk(2'b10);
      cmd(OP_TERM, 24'h0, 8);
      mode_chk(2'b10);
      cmd(OP_LOCK, 24'h001000, 32);
      reg_chk("lock_lo", REG_LOCK_LO, 32'h0, RESP_OKAY);
      r0 = n_rst;
      l0 = n_lost;
      cmd(OP_RESUME, 24'h0, 8);
      mode_chk(2'b00);
      chk("resets", n_rst, r0);
      cmd(OP_PD, 24'h0, 8);
      cmd(OP_RST_EN, 24'h0, 8);
      cmd(OP_RST, 24'h0, 8);
      mode_chk(2'b00);
      chk("resets", n_rst, r0 + 1);
      chk("lost", n_lost, l0);
      axi_wr(REG_SR4, 32'h00);
      cmd(OP_PD, 24'h0, 8);
      mode_chk(2'b01);
      chk("lost", n_lost, l0 + 1);
      cmd(OP_RST_EN, 24'h0, 8);
      cmd(OP_RST, 24'h0, 8);
      mode_chk(2'b01);
      r0 = n_rst;
      cmd(OP_RESUME, 24'h0, 8);
      mode_chk(2'b00);
      chk("resets", n_rst, r0 + 1);
      axi_wr(REG_SR4, 32'h80);
      cmd(OP_PD_LEGACY, 24'h0, 8);
      mode_chk(2'b01);
      cmd(8'h00, 24'h0, 0);
      mode_chk(2'b01);
      l0 = n_lost;
      jedec_reset <= 1'b1;
      repeat (4) @(posedge mclk);
      jedec_reset <= 1'b0;
      repeat (8) @(posedge mclk);
      mode_chk(2'b00);
      chk("lost", n_lost, l0 + 1);
      axi_wr(REG_SR3, 32'h84);
      cmd(OP_PD, 24'h0, 8);
      mode_chk(2'b10);
      hw_reset_n <= 1'b0;
      repeat (4) @(posedge mclk);
      hw_reset_n <= 1'b1;
      repeat (8) @(posedge mclk);
      mode_chk(2'b00);
   endtask
   task automatic t_pe();
      pe_busy <= 1'b1;
      r0 = n_rst;
      l0 = n_halt;
      cmd(OP_TERM, 24'h0, 8);
      chk("halts", n_halt, l0 + 1);
      chk("resets", n_rst, r0);
      cmd(OP_RST_EN, 24'h0, 8);
      cmd(OP_RST, 24'h0, 8);
      chk("resets", n_rst, r0 + 1);
      pe_busy <= 1'b0;
   endtask
   initial
   begin
      {rst_n, awvalid, wvalid, bready, arvalid, rready, jedec_reset, pe_busy} = '0;
      {awaddr, wdata, araddr, pe_addr} = '0;
      wstrb = 4'hf;
      hw_reset_n = 1'b1;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      t_reset();
      t_lock();
      t_power();
      t_pe();
      complete_run();
   end
endmodule
`default_nettype wire
